// file: design/adc_conversion_control.sv
`timescale 1ns/100ps
// What this block does
// - Codes 0..23 route external channels in order
// - Code 26 temperature sensor, 27 bandgap
// - Codes 24, 25 reserved, undefined result
// - Codes 28, 29 high reference, 30 low
// - All ones powers off, isolates input
// - Four conversion clock sources selectable
// - Alternate source is external reference clock
// - Source divided by ratio; software keeps range
// - Alternate clock ok in wait, not stop
// - Hardware trigger starts on counter overflow
// - Triggers accepted in run, wait, light stop
// - Register write or trigger starts conversion
// - Ten-bit approximation, right-justified 10/8 bit
// - Single or continuous; single returns idle
// - Completion flag and interrupt
// - Compare less-than or greater-or-equal
// - Keeps converting in wait; in light stop only on the local clock
module adc_conversion_control #(
	parameter int SAMPLE_LEN = adc_pkg::SAMPLE_TICKS // Sample phase ticks
) (
	input wire logic I_REF_CLK, // 40 MHz clock
	input wire logic I_RST, // Synchronous reset, high
	input wire logic [2:0] I_ADDR, // Register address
	input wire logic [7:0] I_WDATA, // Write data
	input wire logic I_WR, // Write strobe
	input wire logic I_RD, // Read strobe
	output logic [7:0] O_RDATA, // Read data, next cycle
	input wire logic I_HW_CONV_TRIGGER, // Counter overflow pin
	input wire logic I_EXT_REF_CLOCK_OUT, // Alternate clock pin
	input wire logic I_LOCAL_ASYNC_CONV_CLOCK, // Local async clock
	input wire logic I_CMP_HIGH, // Analog comparator, same clock
	input wire logic I_WAIT_MODE, // Wait mode
	input wire logic I_LIGHT_STOP_MODE, // Light stop mode
	input wire logic I_DEEP_STOP_MODE, // Deep stop mode
	output logic O_CONV_IRQ, // Completion interrupt
	output logic O_SAR_POWER, // Converter powered
	output logic O_SAMPLE, // Sample switch closed
	output logic [9:0] O_TRIAL_CODE, // Trial code to the DAC
	output logic [4:0] O_ROUTE_CHAN, // External channel index
	output logic O_ROUTE_EXT_EN, // External channel switch
	output logic O_ROUTE_TEMP, // Temperature sensor switch
	output logic O_ROUTE_BANDGAP, // Bandgap switch
	output logic O_ROUTE_HIGH_REF, // High reference switch
	output logic O_ROUTE_LOW_REF // Low reference switch
);
	// Trigger synchroniser
	logic [2:0] trig_sync_reg, trig_sync_next; // Stage 0 feeds only stage 1
	logic trig_lvl_reg, trig_lvl_next; // Accepted trigger level
	logic hw_evt; // One pulse per accepted rising edge
	// Software-visible registers
	logic coco_reg, coco_next; // Completion flag
	logic aien_reg, aien_next; // Interrupt enable
	logic cont_reg, cont_next; // Continuous mode
	logic [4:0] sel_reg, sel_next; // Selection code
	logic trig_src_reg, trig_src_next; // Hardware trigger chosen
	logic cmp_en_reg, cmp_en_next; // Compare enable
	logic cmp_ge_reg, cmp_ge_next; // Compare greater-or-equal
	logic [9:0] cmpv_reg, cmpv_next; // Compare value
	logic [1:0] div_reg, div_next; // Divider ratio code
	logic ten_reg, ten_next; // Ten-bit mode
	logic [1:0] src_reg, src_next; // Clock source
	logic [9:0] result_reg, result_next; // Result
	logic lock_reg, lock_next; // High byte read, low pending
	// Sequencer
	adc_pkg::conv_state_t state_reg, state_next; // Sequencer state
	logic [3:0] idx_reg, idx_next; // Bit under trial
	logic [9:0] approx_reg, approx_next; // Bits decided so far
	logic [3:0] scnt_reg, scnt_next; // Sample tick count
	// Output images
	logic [7:0] rdata_next; // Read data
	logic irq_next, power_next, sample_next; // Output next values
	logic [9:0] trial_next; // Trial code next
	logic conv_tick; // Conversion clock enable
	logic start, finish, hit; // Sequencer events
	logic [9:0] final_res; // Result at completion

	// One-hot weight of a bit position
	function automatic logic [9:0] weight(input logic [3:0] idx);
		weight = 10'(11'h001 << idx);
	endfunction

	// Match test; eight-bit mode ignores the top two bits
	function automatic logic cmp_match(input logic [9:0] res, input logic [9:0] cv,
			input logic ge, input logic ten);
		logic [9:0] a;
		logic [9:0] b;
		a = ten ? res : {2'h0, res[7:0]};
		b = ten ? cv : {2'h0, cv[7:0]};
		cmp_match = ge ? (a >= b) : (a < b);
	endfunction

	// Conversion clock: stop modes and clock gating decided inside
	conv_clock_gen u_clk (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.i_src(src_reg),
		.i_div(div_reg),
		.i_run(state_reg != adc_pkg::ST_IDLE),
		.i_stop(I_LIGHT_STOP_MODE || I_DEEP_STOP_MODE),
		.i_alt_clk(I_EXT_REF_CLOCK_OUT),
		.i_local_clk(I_LOCAL_ASYNC_CONV_CLOCK),
		.o_tick(conv_tick)
	);

	// Analog switches follow the held selection code
	input_route_decode u_route (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.i_code(sel_reg),
		.o_chan(O_ROUTE_CHAN),
		.o_ext_en(O_ROUTE_EXT_EN),
		.o_temp(O_ROUTE_TEMP),
		.o_bandgap(O_ROUTE_BANDGAP),
		.o_high_ref(O_ROUTE_HIGH_REF),
		.o_low_ref(O_ROUTE_LOW_REF)
	);

	// Trigger edge detection; the counter pin is asynchronous
	always_comb begin
		trig_sync_next = {trig_sync_reg[1:0], I_HW_CONV_TRIGGER};
		trig_lvl_next = trig_lvl_reg;
		if (trig_sync_reg[1] == trig_sync_reg[2]) begin
			trig_lvl_next = trig_sync_reg[2];
		end
		hw_evt = trig_lvl_next && !trig_lvl_reg;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			trig_sync_reg <= 3'h0;
			trig_lvl_reg <= 1'b0;
		end else begin
			trig_sync_reg <= trig_sync_next;
			trig_lvl_reg <= trig_lvl_next;
		end
	end

	// Registers, sequencer and outputs
	always_comb begin
		coco_next = coco_reg;
		aien_next = aien_reg;
		cont_next = cont_reg;
		sel_next = sel_reg;
		trig_src_next = trig_src_reg;
		cmp_en_next = cmp_en_reg;
		cmp_ge_next = cmp_ge_reg;
		cmpv_next = cmpv_reg;
		div_next = div_reg;
		ten_next = ten_reg;
		src_next = src_reg;
		result_next = result_reg;
		lock_next = lock_reg;
		state_next = state_reg;
		idx_next = idx_reg;
		approx_next = approx_reg;
		scnt_next = scnt_reg;
		start = 1'b0;
		finish = 1'b0;
		final_res = 10'h000;
		hit = 1'b0;
		// Sequencer steps on conversion clock ticks only
		unique case (state_reg)
			adc_pkg::ST_IDLE: begin
			end
			adc_pkg::ST_SAMPLE: begin
				if (conv_tick) begin
					scnt_next = scnt_reg + 4'h1;
					if (scnt_reg == 4'(SAMPLE_LEN - 1)) begin
						state_next = adc_pkg::ST_CONVERT;
						idx_next = ten_reg ? 4'h9 : 4'h7;
						approx_next = 10'h000;
					end
				end
			end
			adc_pkg::ST_CONVERT: begin
				if (conv_tick) begin
					// Keep the trial bit if input is at or above it
					if (I_CMP_HIGH) begin
						approx_next = approx_reg | weight(idx_reg);
					end
					idx_next = idx_reg - 4'h1;
					if (idx_reg == 4'h0) begin
						finish = 1'b1;
					end
				end
			end
		endcase
		// Completion: compare, store, flag, then idle or again
		if (finish) begin
			final_res = approx_next;
			hit = cmp_match(final_res, cmpv_reg, cmp_ge_reg, ten_reg);
			scnt_next = 4'h0;
			state_next = cont_reg ? adc_pkg::ST_SAMPLE : adc_pkg::ST_IDLE;
		end
		// Register writes; a control-one write aborts what runs
		if (I_WR) begin
			unique case (I_ADDR)
				adc_pkg::OFS_SC1: begin
					aien_next = I_WDATA[adc_pkg::SC1_AIEN];
					cont_next = I_WDATA[adc_pkg::SC1_CONT];
					sel_next = I_WDATA[4:0];
					coco_next = 1'b0;
					state_next = adc_pkg::ST_IDLE;
					finish = 1'b0;
					// All ones never starts a conversion
					if (!trig_src_reg && I_WDATA[4:0] != adc_pkg::SEL_OFF) begin
						start = 1'b1;
					end
				end
				adc_pkg::OFS_SC2: begin
					trig_src_next = I_WDATA[adc_pkg::SC2_TRIG];
					cmp_en_next = I_WDATA[adc_pkg::SC2_CMP_EN];
					cmp_ge_next = I_WDATA[adc_pkg::SC2_CMP_GE];
				end
				adc_pkg::OFS_CMP_HI: cmpv_next[9:8] = I_WDATA[1:0];
				adc_pkg::OFS_CMP_LO: cmpv_next[7:0] = I_WDATA;
				adc_pkg::OFS_CFG: begin
					div_next = I_WDATA[adc_pkg::CFG_DIV_LSB +: 2];
					ten_next = I_WDATA[adc_pkg::CFG_TEN_BIT];
					src_next = I_WDATA[adc_pkg::CFG_SRC_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
		// Reading the high byte in ten-bit mode holds the pair
		if (I_RD && I_ADDR == adc_pkg::OFS_RES_HI && ten_reg) begin
			lock_next = 1'b1;
		end
		if (I_RD && I_ADDR == adc_pkg::OFS_RES_LO) begin
			lock_next = 1'b0;
			coco_next = 1'b0;
		end
		// Hardware start; accepted in run, wait and light stop
		if (trig_src_reg && hw_evt && state_reg == adc_pkg::ST_IDLE
				&& sel_reg != adc_pkg::SEL_OFF && !I_WR) begin
			start = 1'b1;
		end
		if (start) begin
			state_next = adc_pkg::ST_SAMPLE;
			scnt_next = 4'h0;
		end
		// Set wins over the clear of a read in the same cycle
		if (finish && (!cmp_en_reg || hit)) begin
			coco_next = 1'b1;
			// The pair lock only holds in ten-bit mode
			if (!lock_reg || !ten_reg) begin
				result_next = ten_reg ? final_res : {2'h0, final_res[7:0]};
			end
		end
		// Deep stop powers the converter down; wait and light keep it
		if (I_DEEP_STOP_MODE) begin
			state_next = adc_pkg::ST_IDLE;
		end
		// Read mux; unmapped offsets read zero
		rdata_next = 8'h00;
		if (I_RD) begin
			unique case (I_ADDR)
				adc_pkg::OFS_SC1: rdata_next = {coco_reg, aien_reg, cont_reg, sel_reg};
				adc_pkg::OFS_SC2: rdata_next = {state_reg != adc_pkg::ST_IDLE, trig_src_reg,
					cmp_en_reg, cmp_ge_reg, 4'h0};
				adc_pkg::OFS_RES_HI: rdata_next = {6'h00, result_reg[9:8]};
				adc_pkg::OFS_RES_LO: rdata_next = result_reg[7:0];
				adc_pkg::OFS_CMP_HI: rdata_next = {6'h00, cmpv_reg[9:8]};
				adc_pkg::OFS_CMP_LO: rdata_next = cmpv_reg[7:0];
				adc_pkg::OFS_CFG: rdata_next = {1'b0, div_reg, 2'h0, ten_reg, src_reg};
				default: rdata_next = 8'h00;
			endcase
		end
		irq_next = coco_next && aien_next;
		power_next = state_next != adc_pkg::ST_IDLE;
		sample_next = state_next == adc_pkg::ST_SAMPLE;
		trial_next = (state_next == adc_pkg::ST_CONVERT) ? (approx_next | weight(idx_next))
			: 10'h000;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			coco_reg <= 1'b0;
			aien_reg <= 1'b0;
			cont_reg <= 1'b0;
			sel_reg <= adc_pkg::SEL_RESET;
			trig_src_reg <= 1'b0;
			cmp_en_reg <= 1'b0;
			cmp_ge_reg <= 1'b0;
			cmpv_reg <= 10'h000;
			div_reg <= 2'h0;
			ten_reg <= 1'b0;
			src_reg <= adc_pkg::SRC_BUS;
			result_reg <= 10'h000;
			lock_reg <= 1'b0;
			state_reg <= adc_pkg::ST_IDLE;
			idx_reg <= 4'h0;
			approx_reg <= 10'h000;
			scnt_reg <= 4'h0;
			O_RDATA <= adc_pkg::BYTE_RESET;
			O_CONV_IRQ <= 1'b0;
			O_SAR_POWER <= 1'b0;
			O_SAMPLE <= 1'b0;
			O_TRIAL_CODE <= 10'h000;
		end else begin
			coco_reg <= coco_next;
			aien_reg <= aien_next;
			cont_reg <= cont_next;
			sel_reg <= sel_next;
			trig_src_reg <= trig_src_next;
			cmp_en_reg <= cmp_en_next;
			cmp_ge_reg <= cmp_ge_next;
			cmpv_reg <= cmpv_next;
			div_reg <= div_next;
			ten_reg <= ten_next;
			src_reg <= src_next;
			result_reg <= result_next;
			lock_reg <= lock_next;
			state_reg <= state_next;
			idx_reg <= idx_next;
			approx_reg <= approx_next;
			scnt_reg <= scnt_next;
			O_RDATA <= rdata_next;
			O_CONV_IRQ <= irq_next;
			O_SAR_POWER <= power_next;
			O_SAMPLE <= sample_next;
			O_TRIAL_CODE <= trial_next;
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	off_no_start_a: assert property (I_WR && I_ADDR == 3'h0 && I_WDATA[4:0] == 5'h1F
		|=> state_reg == adc_pkg::ST_IDLE && !O_SAR_POWER)
		else $error("Off code started the converter");
	sw_start_a: assert property (I_WR && I_ADDR == 3'h0 && !trig_src_reg &&
		I_WDATA[4:0] != 5'h1F && !I_DEEP_STOP_MODE |=> state_reg == adc_pkg::ST_SAMPLE)
		else $error("Software write did not start");
	hw_start_a: assert property (hw_evt && trig_src_reg && state_reg == adc_pkg::ST_IDLE &&
		sel_reg != 5'h1F && !I_WR && !I_DEEP_STOP_MODE |=> state_reg == adc_pkg::ST_SAMPLE)
		else $error("Trigger did not start");
	trig_once_a: assert property (hw_evt |=> !hw_evt)
		else $error("Trigger edge counted twice");
	single_idle_a: assert property (finish && !cont_reg && !I_WR && !I_DEEP_STOP_MODE
		|=> state_reg == adc_pkg::ST_IDLE)
		else $error("Single conversion did not idle");
	flag_set_a: assert property (finish && !cmp_en_reg
		|=> coco_reg && O_CONV_IRQ == aien_reg)
		else $error("Completion flag missing");
	cmp_hold_a: assert property (finish && cmp_en_reg && !hit |=> $stable(result_reg))
		else $error("Failed compare changed result");
	eight_bit_a: assert property (finish && !ten_reg && (!cmp_en_reg || hit)
		|=> result_reg[9:8] == 2'h0)
		else $error("Eight-bit result not justified");
	deep_stop_a: assert property (I_DEEP_STOP_MODE |=> state_reg == adc_pkg::ST_IDLE)
		else $error("Converter ran in deep stop");
	finish_c: cover property (finish && hit);
	hw_run_c: cover property (hw_evt && trig_src_reg ##1 state_reg == adc_pkg::ST_SAMPLE);
	cont_c: cover property (finish && cont_reg);
endmodule

// file: design/adc_pkg.sv
package adc_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] OFS_SC1 = 3'h0;
	localparam logic [2:0] OFS_SC2 = 3'h1;
	localparam logic [2:0] OFS_RES_HI = 3'h2;
	localparam logic [2:0] OFS_RES_LO = 3'h3;
	localparam logic [2:0] OFS_CMP_HI = 3'h4;
	localparam logic [2:0] OFS_CMP_LO = 3'h5;
	localparam logic [2:0] OFS_CFG = 3'h6;
	// Field positions, status and control one
	localparam int SC1_COCO = 7;
	localparam int SC1_AIEN = 6;
	localparam int SC1_CONT = 5;
	// Field positions, status and control two
	localparam int SC2_ACTIVE = 7;
	localparam int SC2_TRIG = 6;
	localparam int SC2_CMP_EN = 5;
	localparam int SC2_CMP_GE = 4;
	// Field positions, configuration
	localparam int CFG_DIV_LSB = 5;
	localparam int CFG_TEN_BIT = 2;
	localparam int CFG_SRC_LSB = 0;
	// Input selection codes
	localparam logic [4:0] SEL_LAST_EXT = 5'h17;
	localparam logic [4:0] SEL_RES_A = 5'h18;
	localparam logic [4:0] SEL_RES_B = 5'h19;
	localparam logic [4:0] SEL_TEMP = 5'h1A;
	localparam logic [4:0] SEL_BANDGAP = 5'h1B;
	localparam logic [4:0] SEL_HIGH_A = 5'h1C;
	localparam logic [4:0] SEL_HIGH_B = 5'h1D;
	localparam logic [4:0] SEL_LOW = 5'h1E;
	localparam logic [4:0] SEL_OFF = 5'h1F;
	// Conversion clock source codes
	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_BUS_HALF = 2'h1;
	localparam logic [1:0] SRC_ALT = 2'h2;
	localparam logic [1:0] SRC_LOCAL = 2'h3;
	// Reset values
	localparam logic [4:0] SEL_RESET = 5'h1F;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Sample phase length in conversion clock ticks
	localparam int SAMPLE_TICKS = 4;
	// Conversion sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage

// file: design/input_route_decode.sv
`timescale 1ns/100ps
// Turns the held selection code into registered analog switch enables
module input_route_decode (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Synchronous reset
	input wire logic [4:0] i_code, // Selection code
	output logic [4:0] o_chan, // External channel index
	output logic o_ext_en, // External channel switch
	output logic o_temp, // Temperature sensor switch
	output logic o_bandgap, // Bandgap switch
	output logic o_high_ref, // High reference switch
	output logic o_low_ref // Low reference switch
);
	logic [4:0] chan_next; // Next channel index
	logic ext_next, temp_next, bg_next, hi_next, lo_next; // Next enables

	// Decode; reserved and off codes open every switch
	always_comb begin
		chan_next = 5'h00;
		ext_next = 1'b0;
		temp_next = 1'b0;
		bg_next = 1'b0;
		hi_next = 1'b0;
		lo_next = 1'b0;
		if (i_code <= adc_pkg::SEL_LAST_EXT) begin
			ext_next = 1'b1;
			chan_next = i_code;
		end
		temp_next = (i_code == adc_pkg::SEL_TEMP);
		bg_next = (i_code == adc_pkg::SEL_BANDGAP);
		hi_next = (i_code == adc_pkg::SEL_HIGH_A) || (i_code == adc_pkg::SEL_HIGH_B);
		lo_next = (i_code == adc_pkg::SEL_LOW);
	end

	// Register the enables so the switches see no decode glitches
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_chan <= 5'h00;
			o_ext_en <= 1'b0;
			o_temp <= 1'b0;
			o_bandgap <= 1'b0;
			o_high_ref <= 1'b0;
			o_low_ref <= 1'b0;
		end else begin
			o_chan <= chan_next;
			o_ext_en <= ext_next;
			o_temp <= temp_next;
			o_bandgap <= bg_next;
			o_high_ref <= hi_next;
			o_low_ref <= lo_next;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	ext_route_a: assert property (i_code <= 5'h17 |=> o_ext_en && o_chan == $past(i_code))
		else $error("External channel not routed");
	reserved_open_a: assert property ((i_code == 5'h18 || i_code == 5'h19) |=>
		!(o_ext_en || o_temp || o_bandgap || o_high_ref || o_low_ref))
		else $error("Reserved code routed a source");
	off_isolate_a: assert property (i_code == 5'h1F |=>
		!(o_ext_en || o_temp || o_bandgap || o_high_ref || o_low_ref))
		else $error("Off code left a source routed");
endmodule

// file: design/conv_clock_gen.sv
`timescale 1ns/100ps
// Selects a conversion clock source and divides it into an enable tick
module conv_clock_gen (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Synchronous reset
	input wire logic [1:0] i_src, // Source select
	input wire logic [1:0] i_div, // Divide ratio, power of two
	input wire logic i_run, // Converter busy; idle clears divider
	input wire logic i_stop, // Light or deep stop mode
	input wire logic i_alt_clk, // Alternate clock pin
	input wire logic i_local_clk, // Local asynchronous clock
	output logic o_tick // One cycle per conversion clock
);
	logic [2:0] alt_sync_reg, alt_sync_next; // Alt synchroniser
	logic [2:0] loc_sync_reg, loc_sync_next; // Local synchroniser
	logic alt_lvl_reg, alt_lvl_next; // Accepted alt level
	logic loc_lvl_reg, loc_lvl_next; // Accepted local level
	logic half_reg, half_next; // Bus clock halving toggle
	logic [2:0] cnt_reg, cnt_next; // Divider count
	logic tick_next; // Next tick
	logic src_tick; // Raw source edge

	// Source selection, synchronisers and divider
	always_comb begin
		alt_sync_next = {alt_sync_reg[1:0], i_alt_clk};
		loc_sync_next = {loc_sync_reg[1:0], i_local_clk};
		// Levels move only when stages two and three agree
		alt_lvl_next = (alt_sync_reg[1] == alt_sync_reg[2]) ? alt_sync_reg[2] : alt_lvl_reg;
		loc_lvl_next = (loc_sync_reg[1] == loc_sync_reg[2]) ? loc_sync_reg[2] : loc_lvl_reg;
		half_next = ~half_reg;
		unique case (i_src)
			adc_pkg::SRC_BUS: src_tick = !i_stop;
			adc_pkg::SRC_BUS_HALF: src_tick = !i_stop && half_reg;
			// Alternate source is dead in both stop modes
			adc_pkg::SRC_ALT: src_tick = !i_stop && alt_lvl_next && !alt_lvl_reg;
			adc_pkg::SRC_LOCAL: src_tick = loc_lvl_next && !loc_lvl_reg;
		endcase
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!i_run) begin
			cnt_next = 3'h0;
		end else if (src_tick) begin
			// Ratio 1, 2, 4 or 8 of the chosen source
			if (cnt_reg == 3'((4'h1 << i_div) - 4'h1)) begin
				cnt_next = 3'h0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 3'h1;
			end
		end
	end

	// State registers only
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			alt_sync_reg <= 3'h0;
			loc_sync_reg <= 3'h0;
			alt_lvl_reg <= 1'b0;
			loc_lvl_reg <= 1'b0;
			half_reg <= 1'b0;
			cnt_reg <= 3'h0;
			o_tick <= 1'b0;
		end else begin
			alt_sync_reg <= alt_sync_next;
			loc_sync_reg <= loc_sync_next;
			alt_lvl_reg <= alt_lvl_next;
			loc_lvl_reg <= loc_lvl_next;
			half_reg <= half_next;
			cnt_reg <= cnt_next;
			o_tick <= tick_next;
		end
	end

	alt_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_stop && i_src == 2'h2 |=> !o_tick)
		else $error("Alternate clock ticked in stop");
endmodule

// file: verif/analog_front_model.sv
`timescale 1ns/100ps
// Analog side: input level held at sampling, compared to the trial code
module analog_front_model (
	input wire logic i_sample, // Sample switch closed
	input wire logic [9:0] i_trial, // Trial code from the DAC
	input wire logic [9:0] i_level, // Input level, in codes
	input wire logic i_bg_route, // Bandgap switch closed
	input wire logic i_bg_buf_en, // Bandgap buffer powered
	output logic o_cmp_high // High when input at or above trial
);
	logic [9:0] held = 10'h000; // Level caught while sampling
	// Track while sampling, hold through the bit trials
	always_latch begin
		if (i_sample) begin
			// An unbuffered bandgap gives no usable level
			held <= (i_bg_route && !i_bg_buf_en) ? 10'h000 : i_level;
		end
	end
	// Ideal comparator; a real one would add noise near the edge
	assign o_cmp_high = (held >= i_trial);
endmodule

// file: verif/adc_conversion_control_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the conversion control block
module adc_conversion_control_tb;
	logic clk = 1'b0; // 40 MHz clock
	logic rst = 1'b1; // Reset, high
	logic [2:0] addr = 3'h0; // Register offset
	logic [7:0] wdata = 8'h00; // Write data
	logic wr = 1'b0; // Write strobe
	logic rd = 1'b0; // Read strobe
	logic trig = 1'b0; // Counter overflow
	logic altc = 1'b0; // Alternate clock
	logic locc = 1'b0; // Local clock
	logic waitm = 1'b0; // Wait mode
	logic lstop = 1'b0; // Light stop
	logic dstop = 1'b0; // Deep stop
	logic bg_buf_en = 1'b0; // Bandgap buffer enable
	logic [7:0] rdata; // Read data
	logic cmp; // Comparator
	logic irq; // Interrupt
	logic pwr; // Converter power
	logic smp; // Sample phase
	logic [9:0] trial; // Trial code
	logic [4:0] rchan; // Route index
	logic [4:0] rsw; // Switches: ext,temp,bg,hi,lo
	int num_errors = 0; // Mismatches
	int comparisons = 0; // Checks made
	int cycles = 0; // Watchdog
	// Clocks; the two async sources are unrelated in phase
	always #12.5 clk = ~clk;
	always #30 altc = ~altc;
	always #35 locc = ~locc;
	adc_conversion_control dut_u (
		.I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_HW_CONV_TRIGGER(trig),
		.I_EXT_REF_CLOCK_OUT(altc), .I_LOCAL_ASYNC_CONV_CLOCK(locc),
		.I_CMP_HIGH(cmp), .I_WAIT_MODE(waitm), .I_LIGHT_STOP_MODE(lstop),
		.I_DEEP_STOP_MODE(dstop), .O_CONV_IRQ(irq), .O_SAR_POWER(pwr),
		.O_SAMPLE(smp), .O_TRIAL_CODE(trial), .O_ROUTE_CHAN(rchan),
		.O_ROUTE_EXT_EN(rsw[4]), .O_ROUTE_TEMP(rsw[3]), .O_ROUTE_BANDGAP(rsw[2]),
		.O_ROUTE_HIGH_REF(rsw[1]), .O_ROUTE_LOW_REF(rsw[0])
	);
	analog_front_model model_u (
		.i_sample(smp), .i_trial(trial), .i_level(10'h2A5), .i_bg_route(rsw[2]),
		.i_bg_buf_en(bg_buf_en), .o_cmp_high(cmp)
	);
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// One quiet edge, so a next write never re-raises the strobe in this step
		@(posedge clk);
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// Bounded wait for the interrupt
	task automatic wait_irq(input int cap, output int n);
		n = 0;
		while (irq !== 1'b1 && n < cap) begin
			@(posedge clk);
			n++;
		end
	endtask
	// One conversion that must complete with the held level
	task automatic conv_ok(input logic [7:0] c1, input int cap);
		logic [7:0] d;
		int n;
		wr_reg(3'h0, c1);
		wait_irq(cap, n);
		chk(10'(irq), 10'h001);
		// High byte first, then low, which releases the pair lock
		rd_reg(3'h2, d);
		chk(10'(d), 10'h002);
		rd_reg(3'h3, d);
		chk(10'(d), 10'h0A5);
	endtask
	task automatic t_reset();
		logic [7:0] d;
		rd_reg(3'h0, d);
		chk(10'(d), 10'h01F);
		chk({rchan, rsw}, 10'h000);
		rd_reg(3'h7, d);
		chk(10'(d), 10'h000);
	endtask
	task automatic t_route();
		logic [9:0] e;
		bg_buf_en <= 1'b1; // Buffer on before the bandgap is converted
		for (int c = 0; c < 32; c++) begin
			wr_reg(3'h0, 8'(c));
			repeat (2) @(posedge clk);
			case (c)
				26: e = 10'h008;
				27: e = 10'h004;
				28, 29: e = 10'h002;
				30: e = 10'h001;
				default: e = (c < 24) ? 10'h010 : 10'h000;
			endcase
			chk(10'(rsw), e);
			if (c < 24) begin
				chk(10'(rchan), 10'(c));
			end
		end
		chk(10'(pwr), 10'h000);
	endtask
	task automatic t_single();
		logic [7:0] d;
		wr_reg(3'h6, 8'h04); // Ten-bit, bus clock, divide by one
		conv_ok(8'h45, 200);
		rd_reg(3'h1, d);
		chk(10'(d), 10'h000);
		chk(10'({irq, pwr}), 10'h000);
	endtask
	task automatic t_compare();
		int n;
		wr_reg(3'h4, 8'h03);
		wr_reg(3'h5, 8'h00); // Compare value above the level
		wr_reg(3'h1, 8'h20); // Less-than
		conv_ok(8'h45, 200);
		wr_reg(3'h1, 8'h30); // Greater-or-equal, must stay quiet
		wr_reg(3'h0, 8'h45);
		wait_irq(100, n);
		chk(10'(irq), 10'h000);
		wr_reg(3'h1, 8'h00);
	endtask
	task automatic t_clocks();
		int n;
		for (int s = 0; s < 4; s++) begin
			wr_reg(3'h6, 8'h04 | 8'(s));
			conv_ok(8'h45, 200);
		end
		wr_reg(3'h6, 8'h64); // Bus clock divided by eight
		wr_reg(3'h0, 8'h45);
		wait_irq(300, n);
		chk(10'(n >= 105 && n <= 125), 10'h001);
		conv_ok(8'h45, 300);
		waitm <= 1'b1;
		wr_reg(3'h6, 8'h06); // Alternate keeps going in wait
		conv_ok(8'h45, 200);
		waitm <= 1'b0;
		lstop <= 1'b1;
		wr_reg(3'h0, 8'h45); // Alternate stalls in light stop
		wait_irq(100, n);
		chk(10'(irq), 10'h000);
		wr_reg(3'h6, 8'h07); // Local still runs
		conv_ok(8'h45, 200);
	endtask
	// Hardware trigger, in light stop on the local source
	task automatic t_hw();
		logic [7:0] d;
		int n;
		wr_reg(3'h1, 8'h40);
		wr_reg(3'h0, 8'h45);
		wait_irq(40, n);
		chk(10'(irq), 10'h000);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		trig <= 1'b0;
		wait_irq(200, n);
		chk(10'(irq), 10'h001);
		rd_reg(3'h3, d);
		wait_irq(80, n);
		chk(10'(irq), 10'h000);
		wr_reg(3'h1, 8'h00);
		lstop <= 1'b0;
	endtask
	task automatic t_cont();
		int n;
		wr_reg(3'h6, 8'h04);
		conv_ok(8'h65, 200);
		repeat (2) @(posedge clk);
		wait_irq(200, n);
		chk(10'(irq), 10'h001);
		wr_reg(3'h0, 8'h1F); // Off code ends the run
		repeat (3) @(posedge clk);
		chk(10'(pwr), 10'h000);
		wr_reg(3'h0, 8'h25); // Continuous again, then deep stop
		dstop <= 1'b1;
		repeat (3) @(posedge clk);
		chk(10'(pwr), 10'h000);
		dstop <= 1'b0;
		repeat (20) @(posedge clk);
		chk(10'(pwr), 10'h000);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_route();
		t_single();
		t_compare();
		t_clocks();
		t_hw();
		t_cont();
		tally_and_finish();
	end
endmodule
